// *** common/pcc_pkg.sv ***
// Constants, carriers and format helpers for the converter configuration bank.
// Assumes one 25 MHz clock and a command-word port decoded by the management link.
// Operation
// [RQ1] Ceiling write refused above 110% of strap
// [RQ2] Code 0x25 holds margin-high output target
// [RQ3] Code 0x26 holds margin-low output target
// [RQ4] Code 0x27 holds output slew in V/ms
// [RQ5] Code 0x28 holds droop slope in mV/A
// [RQ6] Code 0x32 holds duty-cycle ceiling percent
// [RQ7] Code 0x33 holds switching frequency, 1 kHz
// [RQ8] Start conversion when input reaches turn-on
// [RQ9] Stop conversion when input falls to turn-off
// [RQ10] Interleave bits 11:8 give group identifier
// [RQ11] Interleave bits 7:4 give unit count
// [RQ12] Bits 3:0 set phase offset from sync
// [RQ13] Host gives position zero to sync source
// [RQ14] System ties all units to common sync
// [RQ15] Code 0x39 current offset, read only, applied
// [RQ16] Code 0x40 holds overvoltage fault threshold
// [RQ17] Code 0x29 holds loop sense gain
// [RQ18] Code 0x2A holds monitor divider scale
// [RQ19] Output words use five-bit exponent, word mantissa
// [RQ20] Linear words: 5-bit exponent, 11-bit mantissa
package pcc_pkg;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_CEIL = 8'h24;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
    localparam logic [7:0] CMD_SLEW = 8'h27;
    localparam logic [7:0] CMD_DROOP = 8'h28;
    localparam logic [7:0] CMD_LOOP_GAIN = 8'h29;
    localparam logic [7:0] CMD_MON_SCALE = 8'h2A;
    localparam logic [7:0] CMD_DUTY_MAX = 8'h32;
    localparam logic [7:0] CMD_SW_FREQ = 8'h33;
    localparam logic [7:0] CMD_VIN_ON = 8'h35;
    localparam logic [7:0] CMD_VIN_OFF = 8'h36;
    localparam logic [7:0] CMD_SPREAD = 8'h37;
    localparam logic [7:0] CMD_CUR_OFF = 8'h39;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;

    // ----------------------------------------
    // Storage indices
    // ----------------------------------------
    localparam int NUM_REGS = 14;
    localparam logic [3:0] IDX_CEIL = 4'h0;
    localparam logic [3:0] IDX_MARGIN_HIGH = 4'h1;
    localparam logic [3:0] IDX_MARGIN_LOW = 4'h2;
    localparam logic [3:0] IDX_SLEW = 4'h3;
    localparam logic [3:0] IDX_DROOP = 4'h4;
    localparam logic [3:0] IDX_LOOP_GAIN = 4'h5;
    localparam logic [3:0] IDX_MON_SCALE = 4'h6;
    localparam logic [3:0] IDX_DUTY_MAX = 4'h7;
    localparam logic [3:0] IDX_SW_FREQ = 4'h8;
    localparam logic [3:0] IDX_VIN_ON = 4'h9;
    localparam logic [3:0] IDX_VIN_OFF = 4'hA;
    localparam logic [3:0] IDX_SPREAD = 4'hB;
    localparam logic [3:0] IDX_CUR_OFF = 4'hC;
    localparam logic [3:0] IDX_OV_LIMIT = 4'hD;

    // ----------------------------------------
    // Fields, reset values, scaling
    // ----------------------------------------
    localparam int GRP_MSB = 11;
    localparam int GRP_LSB = 8;
    localparam int CNT_MSB = 7;
    localparam int CNT_LSB = 4;
    localparam int POS_MSB = 3;
    localparam int POS_LSB = 0;
    localparam int LIN_EXP_LSB = 11;
    localparam int FIX_FRAC = 16;
    localparam logic [5:0] FIX_SHIFT = 6'h10;
    localparam logic [15:0] RST_CFG_WORD = 16'h0000;
    localparam logic [15:0] RST_CUR_OFFSET = 16'h0000;
    localparam logic [23:0] CEIL_PCT_LIMIT = 24'h00006E;
    localparam logic [23:0] CEIL_PCT_BASE = 24'h000064;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } pcc_req_type;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [15:0] rdata;
    } pcc_rsp_type;

    typedef struct packed {
        logic hit;
        logic [3:0] idx;
    } pcc_dec_type;

    typedef struct packed {
        logic [15:0] ceiling, margin_high, margin_low, slew, droop, loop_gain;
        logic [15:0] mon_scale, duty_max, sw_freq, vin_on, vin_off, ov_limit;
        logic [3:0] group_id, group_size, position;
    } pcc_config_type;

    // Command code to storage index
    function automatic pcc_dec_type cmd_decode(input logic [7:0] code);
        pcc_dec_type d;
        d.hit = 1'b1;
        case (code)
            CMD_CEIL: d.idx = IDX_CEIL;
            CMD_MARGIN_HIGH: d.idx = IDX_MARGIN_HIGH;
            CMD_MARGIN_LOW: d.idx = IDX_MARGIN_LOW;
            CMD_SLEW: d.idx = IDX_SLEW;
            CMD_DROOP: d.idx = IDX_DROOP;
            CMD_LOOP_GAIN: d.idx = IDX_LOOP_GAIN;
            CMD_MON_SCALE: d.idx = IDX_MON_SCALE;
            CMD_DUTY_MAX: d.idx = IDX_DUTY_MAX;
            CMD_SW_FREQ: d.idx = IDX_SW_FREQ;
            CMD_VIN_ON: d.idx = IDX_VIN_ON;
            CMD_VIN_OFF: d.idx = IDX_VIN_OFF;
            CMD_SPREAD: d.idx = IDX_SPREAD;
            CMD_CUR_OFF: d.idx = IDX_CUR_OFF;
            CMD_OV_LIMIT: d.idx = IDX_OV_LIMIT;
            default: begin
                d.hit = 1'b0;
                d.idx = IDX_CEIL;
            end
        endcase
        return d;
    endfunction

    // Linear word to signed fixed point, 16 fraction bits
    function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
        logic [5:0] sh;
        logic signed [47:0] m;
        sh = {w[15], w[15:LIN_EXP_LSB]} + FIX_SHIFT;
        m = {{37{w[LIN_EXP_LSB-1]}}, w[LIN_EXP_LSB-1:0]};
        return m <<< sh;
    endfunction

    // Output-format word to unsigned fixed point, 16 fraction bits
    function automatic logic [47:0] vout_to_fix(input logic [15:0] m, input logic [4:0] e);
        logic [5:0] sh;
        sh = {e[4], e} + FIX_SHIFT;
        return {32'h00000000, m} << sh;
    endfunction

endpackage

// *** core/pcc_config_bank.sv ***
// Configuration word bank of the power converter, reached by command code.
// Assumes the management link delivers decoded word commands on one clock.
`timescale 1ns/10ps
module pcc_config_bank (
    input wire logic clock,
    input wire logic rst_b,
    input wire pcc_pkg::pcc_req_type req,
    output pcc_pkg::pcc_rsp_type rsp,
    input wire logic [15:0] strap_vout,
    input wire logic [4:0] vout_exponent,
    input wire logic [15:0] vin_measured,
    input wire logic [15:0] iout_raw,
    input wire logic sync_pin,
    output pcc_pkg::pcc_config_type cfg,
    output logic conv_enable,
    output logic phase_pulse,
    output logic signed [47:0] iout_report_fix,
    output logic [47:0] ov_limit_fix,
    output logic [47:0] ceiling_fix
);
    import pcc_pkg::*;

    typedef enum {CONV_IDLE, CONV_RUN} pcc_conv_type;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [15:0] word_reg [NUM_REGS]; // Stored words
    logic [15:0] word_next [NUM_REGS];
    pcc_rsp_type rsp_reg, rsp_next; // Answer to a command
    pcc_dec_type dec; // Decoded command code
    logic [23:0] ceil_scaled; // Requested ceiling times base
    logic [23:0] strap_scaled; // Strap times limit percent
    logic ceil_ok; // Ceiling request within limit
    logic [15:0] strap_ff1_reg, strap_ff2_reg, strap_ff3_reg; // Strap synchroniser
    logic [15:0] strap_reg, strap_next; // Captured strap
    logic strap_taken_reg, strap_taken_next; // Strap captured
    logic [1:0] fill_reg, fill_next; // Edges since release, saturating; stages hold pin data at 3
    logic strap_load; // Capture this cycle
    logic sync_ff1_reg, sync_ff2_reg, sync_ff3_reg; // Sync synchroniser
    logic sync_level_reg, sync_level_next; // Accepted sync level
    logic sync_rise; // Accepted rising edge
    pcc_conv_type conv_reg, conv_next; // Conversion state
    logic signed [47:0] vin_fix, on_fix, off_fix; // Decoded input levels
    logic signed [47:0] iout_fix_reg, iout_fix_next; // Reported current
    logic [47:0] ov_fix_reg, ov_fix_next; // Decoded fault threshold
    logic [47:0] ceil_fix_reg, ceil_fix_next; // Decoded ceiling

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------

    // Three stages for strap and sync pins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_ff1_reg <= 16'h0000;
            strap_ff2_reg <= 16'h0000;
            strap_ff3_reg <= 16'h0000;
            sync_ff1_reg <= 1'b0;
            sync_ff2_reg <= 1'b0;
            sync_ff3_reg <= 1'b0;
        end else begin
            strap_ff1_reg <= strap_vout;
            strap_ff2_reg <= strap_ff1_reg;
            strap_ff3_reg <= strap_ff2_reg;
            sync_ff1_reg <= sync_pin;
            sync_ff2_reg <= sync_ff1_reg;
            sync_ff3_reg <= sync_ff2_reg;
        end
    end

    // Strap is caught once, after the stages have filled and two of them agree;
    // the reset zeros in the stages would otherwise be caught as the strap
    always_comb begin
        fill_next = fill_reg + {1'b0, !(&fill_reg)};
        strap_load = (&fill_reg) && !strap_taken_reg && (strap_ff2_reg == strap_ff3_reg);
        strap_next = strap_load ? strap_ff3_reg : strap_reg;
        strap_taken_next = strap_taken_reg | strap_load;
    end

    // Sync level changes only when two stages agree
    always_comb begin
        sync_level_next = sync_level_reg;
        if (sync_ff2_reg == sync_ff3_reg) begin
            sync_level_next = sync_ff3_reg;
        end
    end
    assign sync_rise = (sync_ff2_reg == sync_ff3_reg) && sync_ff3_reg && !sync_level_reg;

    // Strap and sync state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_reg <= 16'h0000;
            strap_taken_reg <= 1'b0;
            fill_reg <= 2'h0;
            sync_level_reg <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            strap_reg <= strap_next;
            strap_taken_reg <= strap_taken_next;
            sync_level_reg <= sync_level_next;
        end
    end

    // ----------------------------------------
    // Command handling
    // ----------------------------------------
    assign dec = cmd_decode(req.code);
    assign ceil_scaled = CEIL_PCT_BASE * {8'h00, req.wdata};
    assign strap_scaled = CEIL_PCT_LIMIT * {8'h00, strap_reg};
    // Ceiling may not exceed the strap level by more than the limit
    assign ceil_ok = strap_taken_reg && (ceil_scaled <= strap_scaled); // [RQ1]

    // Next words and answer
    always_comb begin
        word_next = word_reg;
        rsp_next = '0;
        if (req.valid) begin
            rsp_next.valid = 1'b1;
            if (!dec.hit) begin
                // Unknown code answers refused
                rsp_next.refused = 1'b1;
            end else if (!req.write) begin
                // Every held word reads back
                rsp_next.rdata = word_reg[dec.idx]; // [RQ15]
            end else if (dec.idx == IDX_CUR_OFF) begin
                // Current offset is read only
                rsp_next.refused = 1'b1; // [RQ15]
            end else if (dec.idx == IDX_CEIL && !ceil_ok) begin
                // Ceiling above limit keeps the old value
                rsp_next.refused = 1'b1; // [RQ1]
            end else begin
                // Plain word store
                word_next[dec.idx] = req.wdata; // [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7]
            end
        end
        // Ceiling starts at the strapped level
        if (strap_load) begin
            word_next[IDX_CEIL] = strap_ff3_reg; // [RQ1]
        end
    end

    // Word storage
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                word_reg[i] <= RST_CFG_WORD;
            end
            word_reg[IDX_CUR_OFF] <= RST_CUR_OFFSET;
            rsp_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                word_reg[i] <= word_next[i];
            end
            rsp_reg <= rsp_next;
        end
    end
    assign rsp = rsp_reg;

    // ----------------------------------------
    // Input voltage gate
    // ----------------------------------------
    assign vin_fix = lin_to_fix(vin_measured); // [RQ20]
    assign on_fix = lin_to_fix(word_reg[IDX_VIN_ON]);
    assign off_fix = lin_to_fix(word_reg[IDX_VIN_OFF]);

    // Hysteresis between turn-on and turn-off levels
    always_comb begin
        conv_next = conv_reg;
        case (conv_reg)
            CONV_IDLE: begin
                if (vin_fix >= on_fix) begin
                    conv_next = CONV_RUN; // [RQ8]
                end
            end
            CONV_RUN: begin
                if (vin_fix <= off_fix) begin
                    conv_next = CONV_IDLE; // [RQ9]
                end
            end
            default: conv_next = CONV_IDLE;
        endcase
    end

    // Conversion state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conv_reg <= CONV_IDLE;
        end else begin
            conv_reg <= conv_next;
        end
    end
    assign conv_enable = (conv_reg == CONV_RUN);

    // ----------------------------------------
    // Decoded values
    // ----------------------------------------

    // Offset added to current readings, output words scaled by exponent
    always_comb begin
        iout_fix_next = lin_to_fix(iout_raw) + lin_to_fix(word_reg[IDX_CUR_OFF]); // [RQ15]
        ov_fix_next = vout_to_fix(word_reg[IDX_OV_LIMIT], vout_exponent); // [RQ16] [RQ19]
        ceil_fix_next = vout_to_fix(word_reg[IDX_CEIL], vout_exponent); // [RQ19]
    end

    // Decoded value registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            iout_fix_reg <= '0;
            ov_fix_reg <= '0;
            ceil_fix_reg <= '0;
        end else begin
            iout_fix_reg <= iout_fix_next;
            ov_fix_reg <= ov_fix_next;
            ceil_fix_reg <= ceil_fix_next;
        end
    end
    assign iout_report_fix = iout_fix_reg;
    assign ov_limit_fix = ov_fix_reg;
    assign ceiling_fix = ceil_fix_reg;

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    assign cfg.ceiling = word_reg[IDX_CEIL];
    assign cfg.margin_high = word_reg[IDX_MARGIN_HIGH]; // [RQ2]
    assign cfg.margin_low = word_reg[IDX_MARGIN_LOW]; // [RQ3]
    assign cfg.slew = word_reg[IDX_SLEW]; // [RQ4]
    assign cfg.droop = word_reg[IDX_DROOP]; // [RQ5]
    assign cfg.loop_gain = word_reg[IDX_LOOP_GAIN]; // [RQ17]
    assign cfg.mon_scale = word_reg[IDX_MON_SCALE]; // [RQ18]
    assign cfg.duty_max = word_reg[IDX_DUTY_MAX]; // [RQ6]
    assign cfg.sw_freq = word_reg[IDX_SW_FREQ]; // [RQ7]
    assign cfg.vin_on = word_reg[IDX_VIN_ON];
    assign cfg.vin_off = word_reg[IDX_VIN_OFF];
    assign cfg.ov_limit = word_reg[IDX_OV_LIMIT]; // [RQ16]
    assign cfg.group_id = word_reg[IDX_SPREAD][GRP_MSB:GRP_LSB]; // [RQ10]
    assign cfg.group_size = word_reg[IDX_SPREAD][CNT_MSB:CNT_LSB]; // [RQ11]
    assign cfg.position = word_reg[IDX_SPREAD][POS_MSB:POS_LSB]; // [RQ12]

    // Phase offset from the shared sync clock
    pcc_phase_align u_phase (
        .clock(clock),
        .rst_b(rst_b),
        .sync_rise(sync_rise), // [RQ14]
        .position(cfg.position), // [RQ13]
        .group_size(cfg.group_size),
        .phase_pulse(phase_pulse)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_write(logic [7:0] code);
        req.valid && req.write && req.code == code;
    endsequence

    property p_store(logic [7:0] code, logic [15:0] word);
        s_write(code) |=> rsp.valid && !rsp.refused && word == $past(req.wdata);
    endproperty

    a_ceiling_limit: assert property ( // [RQ1]
        s_write(CMD_CEIL) ##0 !ceil_ok |=> rsp.refused && $stable(cfg.ceiling))
        else $error("ceiling above limit was taken");
    a_margin_high_store: assert property (p_store(CMD_MARGIN_HIGH, cfg.margin_high)) // [RQ2]
        else $error("margin-high word not stored");
    a_margin_low_store: assert property (p_store(CMD_MARGIN_LOW, cfg.margin_low)) // [RQ3]
        else $error("margin-low word not stored");
    a_slew_store: assert property (p_store(CMD_SLEW, cfg.slew)) // [RQ4]
        else $error("slew word not stored");
    a_droop_store: assert property (p_store(CMD_DROOP, cfg.droop)) // [RQ5]
        else $error("droop word not stored");
    a_duty_store: assert property (p_store(CMD_DUTY_MAX, cfg.duty_max)) // [RQ6]
        else $error("duty ceiling not stored");
    a_freq_store: assert property (p_store(CMD_SW_FREQ, cfg.sw_freq)) // [RQ7]
        else $error("switching frequency not stored");
    a_turn_on_gate: assert property ( // [RQ8]
        !conv_enable && vin_fix >= on_fix |=> conv_enable)
        else $error("conversion did not start at turn-on level");
    a_turn_off_gate: assert property ( // [RQ9]
        conv_enable && vin_fix <= off_fix |=> !conv_enable)
        else $error("conversion did not stop at turn-off level");
    a_group_id_field: assert property ( // [RQ10]
        s_write(CMD_SPREAD) |=> cfg.group_id == $past(req.wdata[11:8]))
        else $error("group identifier not taken from bits 11:8");
    a_group_size_field: assert property ( // [RQ11]
        s_write(CMD_SPREAD) |=> cfg.group_size == $past(req.wdata[7:4]))
        else $error("unit count not taken from bits 7:4");
    a_offset_read_only: assert property ( // [RQ15]
        s_write(CMD_CUR_OFF) |=> rsp.refused && $stable(word_reg[IDX_CUR_OFF]))
        else $error("current offset write not refused");
    a_offset_applied: assert property ( // [RQ15]
        1'b1 |=> iout_report_fix ==
            lin_to_fix($past(iout_raw)) + lin_to_fix($past(word_reg[IDX_CUR_OFF])))
        else $error("current offset not applied");
    a_ov_store: assert property (p_store(CMD_OV_LIMIT, cfg.ov_limit)) // [RQ16]
        else $error("overvoltage limit not stored");
    a_loop_gain_store: assert property (p_store(CMD_LOOP_GAIN, cfg.loop_gain)) // [RQ17]
        else $error("loop gain not stored");
    a_mon_scale_store: assert property (p_store(CMD_MON_SCALE, cfg.mon_scale)) // [RQ18]
        else $error("monitor scale not stored");
    a_ov_scaling: assert property ( // [RQ19]
        $stable(cfg.ov_limit) && $stable(vout_exponent) |=>
            ov_limit_fix == vout_to_fix($past(cfg.ov_limit), $past(vout_exponent)))
        else $error("overvoltage limit scaled wrongly");

endmodule

// *** core/pcc_phase_align.sv ***
// Interleave phase offset: delays each sync rise by position/size of a period.
// Assumes a one-cycle sync rise pulse already synchronised to clock.
`timescale 1ns/10ps
module pcc_phase_align (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sync_rise,
    input wire logic [3:0] position,
    input wire logic [3:0] group_size,
    output logic phase_pulse
);
    import pcc_pkg::*;

    logic [15:0] count_reg, count_next; // Cycles since last rise
    logic [15:0] period_reg, period_next; // Last measured period
    logic [15:0] wait_reg, wait_next; // Remaining delay
    logic armed_reg, armed_next; // Delay running
    logic [19:0] prod; // Period times position
    logic [15:0] delay; // Offset in cycles

    // ----------------------------------------
    // Delay arithmetic
    // ----------------------------------------
    assign prod = {4'h0, period_reg} * {16'h0000, position};
    // Position outside the group falls back to no offset
    assign delay = (group_size != 4'h0 && position < group_size) ?
                   16'(prod / {16'h0000, group_size}) : 16'h0000; // [RQ12]

    // Next values of the period meter and delay line
    always_comb begin
        count_next = (count_reg == 16'hFFFF) ? count_reg : count_reg + 16'h0001;
        period_next = period_reg;
        wait_next = wait_reg;
        armed_next = armed_reg;
        if (sync_rise) begin
            count_next = 16'h0001;
            period_next = count_reg;
            wait_next = delay; // [RQ12]
            armed_next = 1'b1;
        end else if (armed_reg) begin
            if (wait_reg == 16'h0000) begin
                armed_next = 1'b0;
            end else begin
                wait_next = wait_reg - 16'h0001;
            end
        end
    end

    // Registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= 16'h0000;
            period_reg <= 16'h0000;
            wait_reg <= 16'h0000;
            armed_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            period_reg <= period_next;
            wait_reg <= wait_next;
            armed_reg <= armed_next;
        end
    end

    // Shifted switching edge
    assign phase_pulse = armed_reg && (wait_reg == 16'h0000);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_lead_unit_phase: assert property (@(posedge clock) disable iff (!rst_b) // [RQ12]
        sync_rise && position == 4'h0 |=> phase_pulse)
        else $error("position zero unit not aligned to sync");
    a_phase_one_step: assert property (@(posedge clock) disable iff (!rst_b) // [RQ12]
        sync_rise && delay == 16'h0001 |=> !phase_pulse ##1 phase_pulse)
        else $error("phase offset of one cycle not kept");

endmodule

// *** verif/pcc_config_bank_tb_top.sv ***
// Bench: word writes and reads through the host model, checked against
// expected values. Assumes inputs change at falling edges of clock.
`timescale 1ns/10ps
module pcc_config_bank_tb_top;
    import pcc_pkg::*;
    logic clock, rst_b, sync_pin, conv_enable, phase_pulse;
    logic [15:0] strap_vout, vin_measured, iout_raw, v;
    logic [4:0] vout_exponent;
    logic signed [47:0] iout_report_fix;
    logic [47:0] ov_limit_fix, ceiling_fix;
    pcc_req_type req;
    pcc_rsp_type rsp, r;
    pcc_config_type cfg;
    int miscompares, compares;
    // Plain read/write words
    logic [7:0] codes [11] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
                               8'h32, 8'h33, 8'h35, 8'h36, 8'h40};
    pcc_host_model host (.clock(clock), .rsp(rsp), .req(req));
    pcc_config_bank dut (.clock(clock), .rst_b(rst_b), .req(req), .rsp(rsp),
        .strap_vout(strap_vout), .vout_exponent(vout_exponent),
        .vin_measured(vin_measured), .iout_raw(iout_raw), .sync_pin(sync_pin),
        .cfg(cfg), .conv_enable(conv_enable), .phase_pulse(phase_pulse),
        .iout_report_fix(iout_report_fix), .ov_limit_fix(ov_limit_fix),
        .ceiling_fix(ceiling_fix));
    // Counts and verdict
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One command; a missing answer ends the run
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
        host.xfer(w, c, d, r);
        if (r.valid !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: no answer", $time);
            report_and_stop();
        end
    endtask
    // Conversion gate step: new input level, then sample the gate
    task automatic vin_step(input logic [15:0] lvl, input logic exp);
        vin_measured = lvl;
        repeat (2) @(negedge clock);
        check(conv_enable, exp);
    endtask
    // Sync pin at a period of 4 cycles; pulses seen from cycle 12 on are timed, two expected
    task automatic sync_burst(input int d);
        int hits;
        hits = 0;
        for (int n = 0; n < 20; n++) begin
            sync_pin = (n % 4 < 2);
            @(negedge clock);
            if (phase_pulse === 1'b1 && n >= 12) begin
                hits++;
                check(n % 4, (3 + d) % 4);
            end
        end
        check(hits, 2);
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        rst_b = 1'b0;
        sync_pin = 1'b0;
        strap_vout = 16'h1000;
        vout_exponent = 5'h00;
        vin_measured = 16'h0000;
        iout_raw = 16'h0003;
        miscompares = 0;
        compares = 0;
        repeat (3) @(negedge clock);
        check(rsp, '0);
        rst_b = 1'b1;
        repeat (5) @(negedge clock);
        // Ceiling loads strap, then 110% bound
        cmd(1'b0, CMD_CEIL, 16'h0000);
        check(r.rdata, 16'h1000);
        cmd(1'b1, CMD_CEIL, 16'h119A);
        check(r.refused, 1'b1);
        cmd(1'b1, CMD_CEIL, 16'h1199);
        check(r.refused, 1'b0);
        cmd(1'b0, CMD_CEIL, 16'h0000);
        check(r.rdata, 16'h1199);
        check(ceiling_fix, 48'h000011990000);
        // Every plain word but 0x37 written and read back
        for (int i = 0; i < 11; i++) begin
            v = 16'hA5C3 ^ {codes[i], codes[i]};
            cmd(1'b1, codes[i], v);
            check(r.refused, 1'b0);
            cmd(1'b0, codes[i], 16'h0000);
            check(r.rdata, v);
        end
        check(ov_limit_fix, 48'h0000E5830000);
        vout_exponent = 5'h1F;
        repeat (2) @(negedge clock);
        check(ov_limit_fix, 48'h000072C18000);
        // Sync source takes position zero
        cmd(1'b1, CMD_SPREAD, 16'h0A30);
        check(cfg.group_id, 4'hA);
        check(cfg.group_size, 4'h3);
        check(cfg.position, 4'h0);
        sync_burst(0);
        // Second of three units: offset of one cycle at a period of 4
        cmd(1'b1, CMD_SPREAD, 16'h0A31);
        sync_burst(1);
        // Offset word is read only
        cmd(1'b1, CMD_CUR_OFF, 16'h0007);
        check(r.refused, 1'b1);
        cmd(1'b0, CMD_CUR_OFF, 16'h0000);
        check(r.rdata, 16'h0000);
        check(iout_report_fix, 48'h000000030000);
        cmd(1'b0, 8'h30, 16'h0000);
        check(r.refused, 1'b1);
        // Turn-on 40, turn-off 32
        cmd(1'b1, CMD_VIN_ON, 16'h0028);
        cmd(1'b1, CMD_VIN_OFF, 16'h0020);
        vin_step(16'h0024, 1'b0);
        vin_step(16'h0028, 1'b1);
        vin_step(16'h0024, 1'b1);
        vin_step(16'h0020, 1'b0);
        report_and_stop();
    end
endmodule

// *** verif/pcc_host_model.sv ***
// Host model: issues word commands on the bank's command port.
// Assumes the bench calls xfer; port signals change at falling edges.
`timescale 1ns/10ps
module pcc_host_model (
    input wire logic clock,
    input wire pcc_pkg::pcc_rsp_type rsp,
    output pcc_pkg::pcc_req_type req
);
    import pcc_pkg::*;
    // Idle port from time zero
    initial req = '0;
    // One whole word per command, held across the taking edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output pcc_rsp_type r);
        int n;
        @(negedge clock);
        req = '{valid: 1'b1, write: w, code: c, wdata: d};
        @(negedge clock);
        req = '0;
        // Bounded wait for the one-cycle answer
        for (n = 0; n < 3 && rsp.valid !== 1'b1; n++) begin
            @(negedge clock);
        end
        r = rsp;
    endtask
endmodule
